/* pkg/dpm_consts.svh */
// Operation
// - timer group: running and expiration flags per timer
// - selection eight outputs carrier clock in groups
// - card mode 6..3: protocol detection flags
// - card mode 7,2,1,0: clkfail, eof, data, valid
// - transceive 7..4: prefetch, request, start, enable
// - transceive 3: wait expired; 2..0 state bits
// - receiver data 7..4: processor indications
// - receiver data 3..0: busy, active, reset, bitclk
// - receiver error 2,1,0,7 flags and combination
// - selection six: multi reception length over 28
// - pin chosen from upper nibble of position
// - pin codes: irq, gpo, aux two, aux one
// - two dac values on auxiliary pins
// - aux two input at startup; high enters download
// - after boot idle with aux two low, aux two becomes output
// - first parameter byte selects signal group code
// - low nibble signal, high nibble pin
// - output only when test bus enable set
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH
// ==========================================
// register offsets
`define DPM_ADDR_DIGITAL    12'h000
`define DPM_ADDR_ANALOG     12'h004
`define DPM_ADDR_CONTROL    12'h008
`define DPM_ADDR_STATUS     12'h00c
// ==========================================
// group codes
`define DPM_GRP_CLOCK       8'h01
`define DPM_GRP_TXENC       8'h1b
`define DPM_GRP_TIMER       8'h1d
`define DPM_GRP_CARD        8'h30
`define DPM_GRP_TRX         8'h58
`define DPM_GRP_RXDATA      8'h70
`define DPM_GRP_RXERR       8'h73
// ==========================================
// selections and pins
`define DPM_SEL_CARRIER     4'h8
`define DPM_PIN_IRQ         4'h0
`define DPM_PIN_GPO         4'h1
`define DPM_PIN_AUXILIARY_PIN_TWO        4'h2
`define DPM_PIN_AUXILIARY_PIN_ONE        4'h3
`define DPM_PIN_LAST        4'h3
`define DPM_LEN_LIMIT       8'h1c
`define DPM_ROUTE_RESET     16'h0000
`endif

/* pkg/dpm_pkg.sv */
package dpm_pkg;
   typedef enum logic [2:0]
   {
      DPM_BOOT     = 3'b001,
      DPM_RUN      = 3'b010,
      DPM_DOWNLOAD = 3'b100
   } dpm_boot_t;
endpackage

/* hw/dpm_group_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpm_consts.svh"
module dpm_group_mux
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] group_code,
   input  wire logic [3:0] sel,
   input  wire logic       carrier,
   input  wire logic [7:0] tmr_bus,
   input  wire logic [7:0] card_bus,
   input  wire logic [7:0] trx_bus,
   input  wire logic [7:0] rxd_bus,
   input  wire logic [7:0] rxe_bus,
   input  wire logic [7:0] clk_bus,
   input  wire logic [7:0] txe_bus,
   output logic            sig_out
);
   import dpm_pkg::*;
   logic [7:0] grp;
   logic       valid_grp;
   logic       sig_next;
   logic       sig_reg;
   always_comb
   begin
      valid_grp = 1'b1;
      case (group_code)
         `DPM_GRP_CLOCK  : grp = clk_bus;
         `DPM_GRP_TXENC  : grp = txe_bus & 8'h03;
         `DPM_GRP_TIMER  : grp = tmr_bus & 8'hfc;
         `DPM_GRP_CARD   : grp = card_bus;
         `DPM_GRP_TRX    : grp = trx_bus;
         `DPM_GRP_RXDATA : grp = rxd_bus;
         `DPM_GRP_RXERR  : grp = rxe_bus & 8'hc7;
         default :
         begin
            grp       = 8'h00;
            valid_grp = 1'b0;
         end
      endcase
      if (!valid_grp)
         sig_next = 1'b0;
      else if (sel == `DPM_SEL_CARRIER)
         sig_next = carrier;
      else if (sel[3])
         sig_next = 1'b0;
      else
         sig_next = grp[sel[2:0]];
   end
   // registered so the pin sees one clean edge per clock
   always_ff @(posedge clk)
   begin
      if (rst)
         sig_reg <= 1'b0;
      else
         sig_reg <= sig_next;
   end
   assign sig_out = sig_reg;
endmodule // dpm_group_mux
`default_nettype wire

/* hw/dpm_probe_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpm_consts.svh"
module dpm_probe_mux
(
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic [11:0] PADDR,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        TESTBUS_ENABLE,
   input  wire logic        IDLE_IRQ,
   input  wire logic        CARRIER_CLK,
   input  wire logic [7:0]  CLOCK_GROUP,
   input  wire logic [7:0]  TXENC_GROUP,
   input  wire logic [2:0]  TIMER_RUNNING,
   input  wire logic [2:0]  TIMER_EXPIRED,
   input  wire logic        CARD_CLK_FAIL,
   input  wire logic        CARD_TYPEA_DET,
   input  wire logic        CARD_212_DET,
   input  wire logic        CARD_424_DET,
   input  wire logic        CARD_TYPEB_DET,
   input  wire logic        CARD_EOF_DET,
   input  wire logic        CARD_DATA,
   input  wire logic        CARD_DATA_VALID,
   input  wire logic        TRX_PREFETCH_DONE,
   input  wire logic        TRX_PREFETCH_REQ,
   input  wire logic        TRX_TX_START,
   input  wire logic        TRX_RX_ENABLE,
   input  wire logic        TRX_WAIT_EXPIRED,
   input  wire logic [2:0]  TRX_STATE,
   input  wire logic        SP_COLLISION,
   input  wire logic        SP_END_OF_DATA,
   input  wire logic        SP_DATA_VALID,
   input  wire logic        SP_DATA,
   input  wire logic        RX_BUSY,
   input  wire logic        RX_ACTIVE,
   input  wire logic        RX_CHAIN_RESET,
   input  wire logic        RX_BIT_CLK,
   input  wire logic        ERR_COLLISION,
   input  wire logic        ERR_PROTOCOL,
   input  wire logic        ERR_INTEGRITY,
   input  wire logic        MULTI_RECEPTION,
   input  wire logic [7:0]  FRAME_SIZE_BYTE,
   input  wire logic [7:0]  DAC_SOURCE_A,
   input  wire logic [7:0]  DAC_SOURCE_B,
   input  wire logic        AUX_TWO_IN,
   output logic             AUX_TWO_OUT,
   output logic             AUX_TWO_OE_N,
   output logic             IRQ_PIN_OUT,
   output logic             GENERAL_OUTPUT_ONE,
   output logic             AUX_ONE_OUT,
   output logic [7:0]       DAC_ONE_CODE,
   output logic [7:0]       DAC_TWO_CODE,
   output logic             ANALOG_ACTIVE,
   output logic             DOWNLOAD_MODE
);
   import dpm_pkg::*;
   // ==========================================
   // configuration state
   logic [15:0] route_reg, route_next;
   logic [15:0] ana_reg, ana_next;
   logic [1:0]  ctl_reg, ctl_next;
   dpm_boot_t   boot_reg, boot_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        wr_acc;
   logic        rd_acc;
   logic        map_hit;
   logic        probe_sig;
   logic [7:0]  rxe_bus;
   logic        routed;
   logic [3:0]  pin_sel;
   logic [7:0]  dac_a_src, dac_a_next, dac_b_next;
   logic [7:0]  dac1_reg, dac2_reg;
   assign wr_acc  = PSEL & PENABLE & PWRITE;
   assign rd_acc  = PSEL & ~PWRITE & ~PENABLE;
   assign map_hit = (PADDR == `DPM_ADDR_DIGITAL) || (PADDR == `DPM_ADDR_ANALOG)
                 || (PADDR == `DPM_ADDR_CONTROL) || (PADDR == `DPM_ADDR_STATUS);
   always_comb
   begin
      route_next = route_reg;
      ana_next   = ana_reg;
      ctl_next   = ctl_reg;
      if (wr_acc && PADDR == `DPM_ADDR_DIGITAL)
         route_next = PWDATA[15:0];
      if (wr_acc && PADDR == `DPM_ADDR_ANALOG)
         ana_next = PWDATA[15:0];
      if (wr_acc && PADDR == `DPM_ADDR_CONTROL)
         ctl_next = PWDATA[1:0];
      rdata_next = rdata_reg;
      if (rd_acc)
      begin
         case (PADDR)
            `DPM_ADDR_DIGITAL : rdata_next = {16'h0000, route_reg};
            `DPM_ADDR_ANALOG  : rdata_next = {16'h0000, ana_reg};
            `DPM_ADDR_CONTROL : rdata_next = {30'h0, ctl_reg};
            `DPM_ADDR_STATUS  : rdata_next = {29'h0, boot_reg};
            default           : rdata_next = 32'h00000000;
         endcase
      end
   end
   // ==========================================
   // boot sequencing of the shared pin
   always_comb
   begin
      boot_next = boot_reg;
      case (boot_reg)
         DPM_BOOT :
            if (IDLE_IRQ)
               boot_next = AUX_TWO_IN ? DPM_DOWNLOAD : DPM_RUN;
         DPM_RUN      : boot_next = DPM_RUN;
         DPM_DOWNLOAD : boot_next = DPM_DOWNLOAD;  // left only by reset
         default      : boot_next = DPM_BOOT;
      endcase
   end
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         route_reg <= `DPM_ROUTE_RESET;
         ana_reg   <= `DPM_ROUTE_RESET;
         ctl_reg   <= 2'h0;
         boot_reg  <= DPM_BOOT;
         rdata_reg <= 32'h00000000;
         dac1_reg  <= 8'h00;
         dac2_reg  <= 8'h00;
      end
      else
      begin
         route_reg <= route_next;
         ana_reg   <= ana_next;
         ctl_reg   <= ctl_next;
         boot_reg  <= boot_next;
         rdata_reg <= rdata_next;
         dac1_reg  <= dac_a_next;
         dac2_reg  <= dac_b_next;
      end
   end
   // ==========================================
   // signal group selection
   always_comb
   begin
      rxe_bus    = 8'h00;
      rxe_bus[7] = ERR_INTEGRITY | ERR_PROTOCOL | ERR_COLLISION;
      rxe_bus[6] = MULTI_RECEPTION & (FRAME_SIZE_BYTE > `DPM_LEN_LIMIT);
      rxe_bus[2] = ERR_COLLISION;
      rxe_bus[1] = ERR_PROTOCOL;
      rxe_bus[0] = ERR_INTEGRITY;
   end
   dpm_group_mux u_group
   (
      .clk        (CLOCK),
      .rst        (RESET),
      .group_code (route_reg[15:8]),
      .sel        (route_reg[3:0]),
      .carrier    (CARRIER_CLK),
      .tmr_bus    ({TIMER_RUNNING[0], TIMER_EXPIRED[0], TIMER_RUNNING[1],
                    TIMER_EXPIRED[1], TIMER_RUNNING[2], TIMER_EXPIRED[2], 2'b00}),
      .card_bus   ({CARD_CLK_FAIL, CARD_TYPEA_DET, CARD_212_DET, CARD_424_DET,
                    CARD_TYPEB_DET, CARD_EOF_DET, CARD_DATA, CARD_DATA_VALID}),
      .trx_bus    ({TRX_PREFETCH_DONE, TRX_PREFETCH_REQ, TRX_TX_START,
                    TRX_RX_ENABLE, TRX_WAIT_EXPIRED, TRX_STATE}),
      .rxd_bus    ({SP_COLLISION, SP_END_OF_DATA, SP_DATA_VALID, SP_DATA,
                    RX_BUSY, RX_ACTIVE, RX_CHAIN_RESET, RX_BIT_CLK}),
      .rxe_bus    (rxe_bus),
      .clk_bus    (CLOCK_GROUP),
      .txe_bus    (TXENC_GROUP),
      .sig_out    (probe_sig)
   );
   // ==========================================
   // pin routing; analog mode claims both auxiliary pins
   assign pin_sel = route_reg[7:4];
   assign routed  = TESTBUS_ENABLE & ~ctl_reg[0];
   assign dac_a_src  = DAC_SOURCE_A;
   assign dac_a_next = (TESTBUS_ENABLE & ctl_reg[0] & ana_reg[0]) ? dac_a_src : 8'h00;
   assign dac_b_next = (TESTBUS_ENABLE & ctl_reg[0] & ana_reg[8]) ? DAC_SOURCE_B : 8'h00;
   assign IRQ_PIN_OUT        = routed & (pin_sel == `DPM_PIN_IRQ)  & probe_sig;
   assign GENERAL_OUTPUT_ONE = routed & (pin_sel == `DPM_PIN_GPO)  & probe_sig;
   assign AUX_ONE_OUT        = routed & (pin_sel == `DPM_PIN_AUXILIARY_PIN_ONE) & probe_sig;
   assign AUX_TWO_OUT        = routed & (pin_sel == `DPM_PIN_AUXILIARY_PIN_TWO) & probe_sig
                             & (boot_reg == DPM_RUN);
   // pin stays an input unless boot ends in run, so the strap is never fought
   assign AUX_TWO_OE_N  = (boot_reg != DPM_RUN);
   assign DAC_ONE_CODE  = dac1_reg;
   assign DAC_TWO_CODE  = dac2_reg;
   assign ANALOG_ACTIVE = TESTBUS_ENABLE & ctl_reg[0];
   assign DOWNLOAD_MODE = (boot_reg == DPM_DOWNLOAD);
   // ==========================================
   // bus answer
   assign PRDATA  = rdata_reg;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~map_hit;
endmodule // dpm_probe_mux
`default_nettype wire

/* tb/dpm_probe_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// probe mux checker
module dpm_probe_chk
(
   input wire logic        CLOCK,
   input wire logic        RESET,
   input wire logic [11:0] PADDR,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        TESTBUS_ENABLE,
   input wire logic        IDLE_IRQ,
   input wire logic        CARRIER_CLK,
   input wire logic [2:0]  TIMER_RUNNING,
   input wire logic        AUX_TWO_IN,
   input wire logic        AUX_TWO_OE_N,
   input wire logic        IRQ_PIN_OUT,
   input wire logic        GENERAL_OUTPUT_ONE,
   input wire logic        AUX_ONE_OUT,
   input wire logic        DOWNLOAD_MODE
);
   logic [15:0] cfg_reg;
   logic        ana_reg;
   logic [1:0]  quiet_reg;
   logic        wr;
   logic        dark;
   assign wr = PSEL && PENABLE && PWRITE && PREADY;
   assign dark = !IRQ_PIN_OUT && !GENERAL_OUTPUT_ONE && !AUX_ONE_OUT;
   // edges since last write, so the two-stage mux latency has settled
   always_ff @(posedge CLOCK)
   begin
      if (RESET || wr)
         quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3)
         quiet_reg <= quiet_reg + 2'h1;
      if (RESET)
         cfg_reg <= 16'h0000;
      else if (wr && PADDR == 12'h000)
         cfg_reg <= PWDATA[15:0];
      if (RESET)
         ana_reg <= 1'b0;
      else if (wr && PADDR == 12'h008)
         ana_reg <= PWDATA[0];
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   sequence s_idle;
      AUX_TWO_OE_N && !DOWNLOAD_MODE && IDLE_IRQ;
   endsequence
   sequence s_ok;
      quiet_reg == 2'h3 && !ana_reg && TESTBUS_ENABLE && $past(TESTBUS_ENABLE);
   endsequence
   property p_boot; $fell(RESET) |-> AUX_TWO_OE_N && !DOWNLOAD_MODE; endproperty
   property p_dl; s_idle ##0 AUX_TWO_IN |-> ##[1:2] DOWNLOAD_MODE; endproperty
   property p_run; s_idle ##0 !AUX_TWO_IN |-> ##[1:2] !AUX_TWO_OE_N; endproperty
   property p_gate; !TESTBUS_ENABLE && !$past(TESTBUS_ENABLE) |-> dark; endproperty
   property p_rst; disable iff (1'b0) RESET |=> dark && AUX_TWO_OE_N; endproperty
   property p_tmr; s_ok ##0 cfg_reg == 16'h1d07 |-> IRQ_PIN_OUT == $past(TIMER_RUNNING[0]);
   endproperty
   property p_car; s_ok ##0 cfg_reg == 16'h1d18 |-> GENERAL_OUTPUT_ONE == $past(CARRIER_CLK);
   endproperty
   property p_rsv; s_ok ##0 cfg_reg[7:4] > 4'h3 |-> dark; endproperty
   a_boot: assert property (p_boot) else $error("aux two not input at boot");
   a_dl: assert property (p_dl) else $error("no download entry");
   a_run: assert property (p_run) else $error("aux two not output");
   a_gate: assert property (p_gate) else $error("pins active while disabled");
   a_rst: assert property (p_rst) else $error("reset left pins routed");
   a_tmr: assert property (p_tmr) else $error("timer run flag wrong");
   a_car: assert property (p_car) else $error("carrier wrong");
   a_rsv: assert property (p_rsv) else $error("reserved pin drove");
endmodule // dpm_probe_chk
bind dpm_probe_mux dpm_probe_chk chk_u (.*);
`default_nettype wire

/* tb/dpm_probe_tap.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// observer of the debug pins plus the host strap on aux two
module dpm_probe_tap
(
   input  wire logic  aux_one,
   input  wire logic  aux_two_out,
   input  wire logic  aux_two_oe_n,
   input  wire logic  gpo,
   input  wire logic  irq,
   input  wire logic  strap,
   output logic       aux_two_wire,
   output logic [3:0] pins
);
   // strap reaches the pin only while the device leaves it undriven
   assign aux_two_wire = aux_two_oe_n ? strap : aux_two_out;
   assign pins = {aux_one, aux_two_wire, gpo, irq};
endmodule // dpm_probe_tap
`default_nettype wire

/* tb/dpm_probe_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dpm_probe_mux_tb_top;
   import dpm_pkg::*;
   logic clock, reset, psel, penable, pwrite, tb_en, idle, strap, se;
   logic pready, pslverr, aux_two_out, aux_two_oe_n, irq, gpo, aux_one, aux_two_wire, ana, dl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [63:0] pat;
   logic [7:0]  dac1, dac2;
   logic [3:0]  pins;
   logic [7:0]  grp [0:6] = '{8'h01, 8'h1b, 8'h30, 8'h1d, 8'h58, 8'h70, 8'h73};
   int err_count, n_compared;
   always #12.5 clock = ~clock;
   dpm_probe_mux dut_u
   (
      .CLOCK(clock), .RESET(reset), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TESTBUS_ENABLE(tb_en), .IDLE_IRQ(idle), .CARRIER_CLK(pat[0]), .CLOCK_GROUP(pat[8:1]),
      .TXENC_GROUP(pat[16:9]), .TIMER_RUNNING(pat[19:17]), .TIMER_EXPIRED(pat[22:20]),
      .CARD_CLK_FAIL(pat[23]), .CARD_TYPEA_DET(pat[24]), .CARD_212_DET(pat[25]),
      .CARD_424_DET(pat[26]), .CARD_TYPEB_DET(pat[27]), .CARD_EOF_DET(pat[28]),
      .CARD_DATA(pat[29]), .CARD_DATA_VALID(pat[30]), .TRX_PREFETCH_DONE(pat[31]),
      .TRX_PREFETCH_REQ(pat[32]), .TRX_TX_START(pat[33]), .TRX_RX_ENABLE(pat[34]),
      .TRX_WAIT_EXPIRED(pat[35]), .TRX_STATE(pat[38:36]), .SP_COLLISION(pat[39]),
      .SP_END_OF_DATA(pat[40]), .SP_DATA_VALID(pat[41]), .SP_DATA(pat[42]),
      .RX_BUSY(pat[43]), .RX_ACTIVE(pat[44]), .RX_CHAIN_RESET(pat[45]), .RX_BIT_CLK(pat[46]),
      .ERR_COLLISION(pat[47]), .ERR_PROTOCOL(pat[48]), .ERR_INTEGRITY(pat[49]),
      .MULTI_RECEPTION(pat[50]), .FRAME_SIZE_BYTE(pat[58:51]), .DAC_SOURCE_A(pat[63:56]),
      .DAC_SOURCE_B(pat[7:0]), .AUX_TWO_IN(aux_two_wire), .AUX_TWO_OUT(aux_two_out),
      .AUX_TWO_OE_N(aux_two_oe_n), .IRQ_PIN_OUT(irq), .GENERAL_OUTPUT_ONE(gpo),
      .AUX_ONE_OUT(aux_one), .DAC_ONE_CODE(dac1), .DAC_TWO_CODE(dac2), .ANALOG_ACTIVE(ana),
      .DOWNLOAD_MODE(dl)
   );
   dpm_probe_tap tap_u
   (
      .aux_one(aux_one), .aux_two_out(aux_two_out), .aux_two_oe_n(aux_two_oe_n), .gpo(gpo),
      .irq(irq), .strap(strap), .aux_two_wire(aux_two_wire), .pins(pins)
   );
   // ==========
   // tasks
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // no fixed latency assumed: pready is polled under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clock);
      end
      if (n == 20)
      begin
         err_count++;
         summarize;
      end
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rst;
      reset <= 1'b1;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
   endtask
   task boot(input logic s, input dpm_boot_t st);
      strap <= s;
      rst;
      apb(1'b0, 12'h00c, 32'h0);
      chk("boot", {29'h0, DPM_BOOT}, q);
      idle <= 1'b1;
      @(posedge clock);
      idle <= 1'b0;
      repeat (2) @(posedge clock);
      apb(1'b0, 12'h00c, 32'h0);
      chk("state", {29'h0, st}, q);
   endtask
   function automatic logic [3:0] exp_pins(input logic [7:0] g, input logic [3:0] s,
                                           input logic [3:0] p);
      logic [7:0] b;
      logic       v;
      case (g)
         8'h01: b = pat[8:1];
         8'h1b: b = {6'h00, pat[10:9]};
         8'h1d: b = {pat[17], pat[20], pat[18], pat[21], pat[19], pat[22], 2'h0};
         8'h30: b = {<<{pat[30:23]}};
         8'h58: b = {pat[31], pat[32], pat[33], pat[34], pat[35], pat[38:36]};
         8'h70: b = {<<{pat[46:39]}};
         // selection seven is any receive error at all
         default: b = {pat[47] | pat[48] | pat[49], pat[50] && pat[58:51] > 8'h1c, 3'h0,
                       pat[47], pat[48], pat[49]};
      endcase
      v = (s == 4'h8) ? pat[0] : (s < 4'h8) ? b[s[2:0]] : 1'b0;
      return (p < 4'h4) ? {3'h0, v} << p : 4'h0;
   endfunction
   initial
   begin
      clock = 0;
      reset = 1;
      {psel, penable, pwrite, idle, strap} = '0;
      paddr = '0;
      pwdata = '0;
      tb_en = 1;
      pat = 64'h9e37_79b9_7f4a_7c15;
      boot(1'b1, DPM_DOWNLOAD);
      chk("download", 32'h1, {31'h0, dl});
      boot(1'b0, DPM_RUN);
      chk("oe_n", 32'h0, {31'h0, aux_two_oe_n});
      $display("test boot done");
      for (int gi = 0; gi < 7; gi++)
         for (int s = 0; s < 10; s++)
         begin
            apb(1'b1, 12'h000, {16'h0, grp[gi], 4'((gi + s) % 5), 4'(s)});
            pat <= {pat[62:0], pat[63] ^ pat[62] ^ pat[60] ^ pat[59]};
            repeat (3) @(posedge clock);
            chk("pins", 32'(exp_pins(grp[gi], 4'(s), 4'((gi + s) % 5))), 32'(pins));
         end
      // length end point: 29 bytes flags, exactly 28 does not
      apb(1'b1, 12'h000, 32'h7306);
      pat[58:50] <= 9'h03b;
      repeat (3) @(posedge clock);
      chk("len_over", 32'h1, 32'(pins));
      pat[58:50] <= 9'h039;
      repeat (3) @(posedge clock);
      chk("len_limit", 32'h0, 32'(pins));
      $display("test routing done");
      apb(1'b1, 12'h000, 32'h1d07);
      tb_en <= 1'b0;
      repeat (3) @(posedge clock);
      chk("gated", 32'h0, 32'(pins));
      tb_en <= 1'b1;
      apb(1'b1, 12'h010, 32'hffff);
      chk("slverr", 32'h1, {31'h0, se});
      apb(1'b0, 12'h000, 32'h0);
      chk("latched", 32'h1d07, q);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h004, 32'h101);
      repeat (3) @(posedge clock);
      chk("analog", {23'h0, 1'b1, pat[63:56]}, {23'h0, ana, dac1});
      chk("dac_two", {24'h0, pat[7:0]}, {24'h0, dac2});
      chk("analog_pins", 32'h0, 32'(pins));
      $display("test config done");
      rst;
      apb(1'b0, 12'h000, 32'h0);
      chk("cleared", 32'h0, q);
      summarize;
   end
endmodule // dpm_probe_mux_tb_top
`default_nettype wire
